// ===== hdl/froe_exec.sv
// execute unit for file register ops and direct jump
//
// Operation
// - clear writes zero to the addressed register and always sets the zero flag.
// - invert produces the complement of the register and updates the zero flag.
// - target bit 0 sends the result to the accumulator, 1 back to register 0..31.
// - decrement subtracts one, routes by target bit and updates the zero flag.
// - decrement-skip subtracts one, routes by target bit and touches no status bit.
// - a zero decrement-skip result discards the fetched next op as a two-cycle nop.
// - direct jump loads its 9-bit target into pc bits 8..0.
// - direct jump copies status bits 6..5 into pc bits 10..9.
// - direct jump takes two cycles and leaves all status bits unchanged.
// - increment adds one, routes by target bit and updates the zero flag.
// - increment-skip adds one, leaves status, and skips as a two-cycle op on zero.
`timescale 1ns/1ps
`include "froe_cfg.svh"
module froe_exec
  import froe_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic op_valid,
  input wire froe_op_t op_code,
  input wire logic [4:0] op_reg_idx,
  input wire logic op_to_reg,
  input wire logic [8:0] op_target,
  input wire logic [7:0] op_reg_data,
  input wire logic [7:0] status_in,
  output logic op_ready,
  output logic [7:0] w_out,
  output logic [7:0] status_out,
  output logic [10:0] pc_out,
  output logic pc_load,
  output logic reg_we,
  output logic [4:0] reg_wr_idx,
  output logic [7:0] reg_wr_data,
  output logic discard_next
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] w_reg;
  logic [7:0] status_reg;
  logic [10:0] pc_reg;
  logic pc_load_reg;
  logic reg_we_reg;
  logic [4:0] reg_wr_idx_reg;
  logic [7:0] reg_wr_data_reg;
  logic discard_reg;
  froe_state_t state_reg;
  froe_state_t state_next;
  logic [7:0] result;
  logic writes;
  logic sets_z;
  logic skip_op;
  logic take;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `FROE_ZERO_BYTE);
  endfunction : is_zero

  assign take = ce && op_valid && (state_reg == FROE_ST_EXEC);

  // result datapath; 8-bit targets wrap modulo 256
  always_comb begin
    result = `FROE_ZERO_BYTE;
    writes = 1'b0;
    sets_z = 1'b0;
    skip_op = 1'b0;
    unique case (op_code)
      FROE_OP_CLR: begin
        result = `FROE_ZERO_BYTE;
        writes = 1'b1;
        sets_z = 1'b1;
      end
      FROE_OP_INV: begin
        result = ~op_reg_data;
        writes = 1'b1;
        sets_z = 1'b1;
      end
      FROE_OP_DEC: begin
        result = op_reg_data - `FROE_ONE_BYTE;
        writes = 1'b1;
        sets_z = 1'b1;
      end
      FROE_OP_DECSKIP: begin
        result = op_reg_data - `FROE_ONE_BYTE;
        writes = 1'b1;
        skip_op = 1'b1;
      end
      FROE_OP_INC: begin
        result = op_reg_data + `FROE_ONE_BYTE;
        writes = 1'b1;
        sets_z = 1'b1;
      end
      FROE_OP_INCSKIP: begin
        result = op_reg_data + `FROE_ONE_BYTE;
        writes = 1'b1;
        skip_op = 1'b1;
      end
      FROE_OP_JUMP: begin
        result = `FROE_ZERO_BYTE;
      end
      FROE_OP_NOP: begin
        result = `FROE_ZERO_BYTE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // second cycle of jump or taken skip: the prefetched op is flushed
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FROE_ST_EXEC: begin
        if (take && (op_code == FROE_OP_JUMP || (skip_op && is_zero(result)))) begin
          state_next = FROE_ST_FLUSH;
        end
      end
      FROE_ST_FLUSH: begin
        state_next = FROE_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= FROE_ST_EXEC;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      discard_reg <= 1'b0;
    end else if (ce) begin
      discard_reg <= (state_next == FROE_ST_FLUSH);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // destination select
  always_ff @(posedge clk) begin
    if (!rstn) begin
      w_reg <= `FROE_W_RESET;
    end else if (take && writes && !op_to_reg && op_code != FROE_OP_CLR) begin
      w_reg <= result;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_we_reg <= 1'b0;
      reg_wr_idx_reg <= 5'h00;
      reg_wr_data_reg <= `FROE_ZERO_BYTE;
    end else if (ce) begin
      // clear has no target bit and always writes the register
      reg_we_reg <= take && writes && (op_to_reg || op_code == FROE_OP_CLR);
      reg_wr_idx_reg <= op_reg_idx;
      reg_wr_data_reg <= result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status: only the zero flag ever moves, skip and jump leave it alone
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_reg <= `FROE_STATUS_RESET;
    end else if (ce) begin
      status_reg <= status_in;
      if (take && sets_z) begin
        status_reg[`FROE_Z_BIT] <= is_zero(result);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // direct jump target
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc_reg <= `FROE_PC_RESET;
      pc_load_reg <= 1'b0;
    end else if (ce) begin
      pc_load_reg <= take && (op_code == FROE_OP_JUMP);
      if (take && op_code == FROE_OP_JUMP) begin
        pc_reg <= {status_in[`FROE_PAGE_HI:`FROE_PAGE_LO], op_target};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      op_ready <= 1'b0;
    end else if (ce) begin
      op_ready <= (state_next == FROE_ST_EXEC);
    end
  end

  assign w_out = w_reg;
  assign status_out = status_reg;
  assign pc_out = pc_reg;
  assign pc_load = pc_load_reg;
  assign reg_we = reg_we_reg;
  assign reg_wr_idx = reg_wr_idx_reg;
  assign reg_wr_data = reg_wr_data_reg;
  assign discard_next = discard_reg;

  ////////////////////////////////////////////////////////////////////////
  sequence skip_taken_s;
    take && skip_op && is_zero(result);
  endsequence
  sequence flush_cycle_s;
    discard_next && !op_ready;
  endsequence
  // back in execute with nothing being flushed
  sequence resume_s;
    op_ready && !discard_next;
  endsequence

  clear_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_CLR |=> status_out[`FROE_Z_BIT] && reg_we
      && reg_wr_data == 8'h00) else $error("clear did not zero register and set flag");
  invert_data_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_INV && op_to_reg |=> reg_wr_data == ~$past(op_reg_data))
    else $error("invert result wrong");
  dest_w_a: assert property (@(posedge clk) disable iff (!rstn)
    take && writes && !op_to_reg && op_code != FROE_OP_CLR |=> !reg_we && w_out == $past(result))
    else $error("accumulator destination wrong");
  dec_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_DEC && op_to_reg && op_reg_data == 8'h00
      |=> reg_wr_data == 8'hff && !status_out[`FROE_Z_BIT]) else $error("decrement wrap wrong");
  skip_status_a: assert property (@(posedge clk) disable iff (!rstn)
    take && skip_op && ce |=> status_out == $past(status_in)) else $error("skip changed status");
  skip_flush_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
    skip_taken_s |=> flush_cycle_s ##1 op_ready) else $error("skip did not flush one cycle");
  jump_pc_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_JUMP |=> pc_load && pc_out[8:0] == $past(op_target))
    else $error("jump low bits wrong");
  jump_page_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_JUMP |=> pc_out[10:9] == $past(status_in[6:5]))
    else $error("jump page bits wrong");
  jump_two_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
    take && op_code == FROE_OP_JUMP |=> flush_cycle_s and (status_out == $past(status_in)))
    else $error("jump not two cycles");
  inc_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_INC && op_reg_data == 8'hff |=> status_out[`FROE_Z_BIT])
    else $error("increment zero flag wrong");
  incskip_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
    take && op_code == FROE_OP_INCSKIP && op_reg_data == 8'hff |=> discard_next)
    else $error("increment skip not taken");
  zero_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    take && sets_z && result != 8'h00 |=> !status_out[`FROE_Z_BIT])
    else $error("zero flag not cleared");

  ////////////////////////////////////////////////////////////////////////
  // a refused op in the flush cycle must leave no trace
  flush_refuse_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_reg == FROE_ST_FLUSH |=> !reg_we && !pc_load && !discard_next)
    else $error("op taken during flush");
  decskip_zero_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
    take && op_code == FROE_OP_DECSKIP && op_reg_data == 8'h01 |=> discard_next)
    else $error("decrement skip not taken");
  skip_miss_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
    take && skip_op && !is_zero(result) |=> resume_s)
    else $error("skip flushed on nonzero result");
  jump_resume_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
    take && op_code == FROE_OP_JUMP |=> flush_cycle_s ##1 resume_s)
    else $error("jump did not resume after two cycles");
  jump_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_JUMP |=> !reg_we && w_out == $past(w_out))
    else $error("jump wrote a register");

  decskip_data_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_DECSKIP && op_to_reg
      |=> reg_we && reg_wr_data == $past(op_reg_data) - 8'h01)
    else $error("decrement skip result wrong");
  incskip_data_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_INCSKIP && !op_to_reg
      |=> !reg_we && w_out == $past(op_reg_data) + 8'h01)
    else $error("increment skip result wrong");
  inc_data_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_INC && op_to_reg
      |=> reg_we && reg_wr_data == $past(op_reg_data) + 8'h01)
    else $error("increment result wrong");
  inc_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_INC && op_to_reg && op_reg_data == 8'hff
      |=> reg_wr_data == 8'h00) else $error("increment wrap wrong");
  dec_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_DEC && op_reg_data == 8'h01 |=> status_out[`FROE_Z_BIT])
    else $error("decrement zero flag wrong");
  inv_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_INV && op_reg_data == 8'hff |=> status_out[`FROE_Z_BIT])
    else $error("invert zero flag wrong");
  reg_index_a: assert property (@(posedge clk) disable iff (!rstn)
    take && writes && op_to_reg |=> reg_we && reg_wr_idx == $past(op_reg_idx))
    else $error("register write index wrong");
  clear_keeps_w_a: assert property (@(posedge clk) disable iff (!rstn)
    take && op_code == FROE_OP_CLR |=> w_out == $past(w_out))
    else $error("clear touched the accumulator");
endmodule : froe_exec

// ===== include/froe_cfg.svh
// constants for the file register op execute block
`ifndef FROE_CFG_SVH
`define FROE_CFG_SVH
`define FROE_ZERO_BYTE 8'h00
`define FROE_ONE_BYTE 8'h01
`define FROE_PC_RESET 11'h000
`define FROE_STATUS_RESET 8'h18
`define FROE_W_RESET 8'h00
`define FROE_Z_BIT 2
`define FROE_PAGE_HI 6
`define FROE_PAGE_LO 5
`define FROE_JUMP_CYCLES 2'h2
`define FROE_SKIP_CYCLES 2'h2
`endif

// ===== include/froe_pkg.sv
// types for the file register op execute block
package froe_pkg;
  typedef enum logic [2:0] {
    FROE_OP_NOP = 3'h0,
    FROE_OP_CLR = 3'h1,
    FROE_OP_INV = 3'h2,
    FROE_OP_DEC = 3'h3,
    FROE_OP_DECSKIP = 3'h4,
    FROE_OP_INC = 3'h5,
    FROE_OP_INCSKIP = 3'h6,
    FROE_OP_JUMP = 3'h7
  } froe_op_t;
  typedef enum logic [0:0] {
    FROE_ST_EXEC = 1'h0,
    FROE_ST_FLUSH = 1'h1
  } froe_state_t;
endpackage : froe_pkg

// ===== testbench/froe_exec_tb.sv
// self-checking bench for the file register op execute block
`timescale 1ns/1ps
module froe_exec_tb import froe_pkg::*;;
  logic clk, rstn, ce, op_valid, op_to_reg, op_ready, pc_load, reg_we, discard_next;
  froe_op_t op_code;
  logic [4:0] op_reg_idx, reg_wr_idx;
  logic [8:0] op_target;
  logic [7:0] op_reg_data, status_in, w_out, status_out, reg_wr_data, w_exp;
  logic [10:0] pc_out, pc_exp;
  int err_total, checks;
  logic [7:0] vals [3] = '{8'h00, 8'h01, 8'hff};
  //////////////////////////////////////////////////////////////////////////////////////////
  froe_exec uut (.clk(clk), .rstn(rstn), .ce(ce), .op_valid(op_valid), .op_code(op_code),
    .op_reg_idx(op_reg_idx), .op_to_reg(op_to_reg), .op_target(op_target),
    .op_reg_data(op_reg_data), .status_in(status_in), .op_ready(op_ready), .w_out(w_out),
    .status_out(status_out), .pc_out(pc_out), .pc_load(pc_load), .reg_we(reg_we),
    .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .discard_next(discard_next));
  //////////////////////////////////////////////////////////////////////////////////////////
  task chk(string name, logic [10:0] seen, logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function logic [7:0] calc(froe_op_t op, logic [7:0] d);
    case (op)
      FROE_OP_CLR: return 8'h00;
      FROE_OP_INV: return ~d;
      FROE_OP_DEC, FROE_OP_DECSKIP: return d - 8'h01;
      FROE_OP_INC, FROE_OP_INCSKIP: return d + 8'h01;
      default: return d;
    endcase
  endfunction : calc
  task wrap_up();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task chk_reset();
    chk("w_out", 11'(w_out), 11'h000);
    chk("status_out", 11'(status_out), 11'h018);
    chk("pc_out", pc_out, 11'h000);
    chk("op_ready", 11'(op_ready), 11'h000);
    chk("reg_we", 11'(reg_we), 11'h000);
    chk("pc_load", 11'(pc_load), 11'h000);
    chk("discard_next", 11'(discard_next), 11'h000);
  endtask : chk_reset
  // called at edge+2; presents one op, checks the answer one edge later
  // a stall drops ce for one edge after the checks: every output must stand frozen
  task run_op(froe_op_t op, logic [4:0] idx, logic to_reg, logic [8:0] tgt, logic [7:0] d,
      logic [7:0] st, logic stall);
    logic [7:0] r;
    logic upd, wr, flush, jmp;
    int n;
    n = 0;
    // the last op stays presented through a flush cycle and must be refused there
    while (op_ready !== 1'b1 && n < 8) begin
      @(posedge clk);
      #2;
      n++;
      chk("reg_we", 11'(reg_we), 11'h000);
      chk("pc_load", 11'(pc_load), 11'h000);
    end
    chk("op_ready", 11'(op_ready), 11'h001);
    op_valid = 1'b1;
    op_code = op;
    op_reg_idx = idx;
    op_to_reg = to_reg;
    op_target = tgt;
    op_reg_data = d;
    status_in = st;
    r = calc(op, d);
    jmp = (op == FROE_OP_JUMP);
    upd = op inside {FROE_OP_CLR, FROE_OP_INV, FROE_OP_DEC, FROE_OP_INC};
    wr = (op == FROE_OP_CLR) || (!jmp && to_reg);
    flush = jmp || (op inside {FROE_OP_DECSKIP, FROE_OP_INCSKIP} && r == 8'h00);
    if (!jmp && !wr) begin
      w_exp = r;
    end
    if (jmp) begin
      pc_exp = {st[6:5], tgt};
    end
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge clk);
      #2;
      chk("w_out", 11'(w_out), 11'(w_exp));
      chk("reg_we", 11'(reg_we), 11'(wr));
      if (wr) begin
        chk("reg_wr_idx", 11'(reg_wr_idx), 11'(idx));
        chk("reg_wr_data", 11'(reg_wr_data), 11'(r));
      end
      if (upd) begin
        chk("status_out", 11'(status_out), 11'({st[7:3], r == 8'h00, st[1:0]}));
      end else begin
        chk("status_out", 11'(status_out), 11'(st));
      end
      chk("pc_load", 11'(pc_load), 11'(jmp));
      chk("pc_out", pc_out, pc_exp);
      chk("discard_next", 11'(discard_next), 11'(flush));
      chk("op_ready", 11'(op_ready), 11'(!flush));
      if (!stall) break;
      ce = (pass != 0);
    end
  endtask : run_op
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // generous: about 250 ops of at most three cycles each
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    op_valid = 1'b0;
    op_code = FROE_OP_NOP;
    op_reg_idx = 5'h00;
    op_to_reg = 1'b0;
    op_target = 9'h000;
    op_reg_data = 8'h00;
    status_in = 8'h00;
    err_total = 0;
    checks = 0;
    w_exp = 8'h00;
    pc_exp = 11'h000;
    void'($urandom(11));
    repeat (2) @(posedge clk);
    #2;
    chk_reset();
    rstn = 1'b1;
    // corners: zero, one and all-ones operands to both targets hit the wrap and skip cases
    for (int op = 1; op < 8; op++) begin
      for (int k = 0; k < 6; k++) begin
        run_op(froe_op_t'(op), k[0] ? 5'h1f : 5'h00, k[0], 9'h1ff, vals[k % 3], 8'(k * 36),
          k == 5);
      end
    end
    // a second reset in mid-run
    op_valid = 1'b0;
    rstn = 1'b0;
    @(posedge clk);
    #2;
    chk_reset();
    rstn = 1'b1;
    w_exp = 8'h00;
    pc_exp = 11'h000;
    repeat (200) begin
      run_op(froe_op_t'($urandom_range(1, 7)), 5'($urandom), 1'($urandom), 9'($urandom),
        8'($urandom), 8'($urandom), $urandom_range(0, 3) == 0);
    end
    wrap_up();
  end
endmodule : froe_exec_tb
